// ==== inc/agc_loop_control_cfg.svh ====
`ifndef AGC_LOOP_CONTROL_CFG_SVH
`define AGC_LOOP_CONTROL_CFG_SVH

// Register byte offsets.
`define AGC_OFS_THR_GAINS   8'h00
`define AGC_OFS_LIMITS      8'h04
`define AGC_OFS_STROBE      8'h08
`define AGC_OFS_HELD_GAIN   8'h0c
`define AGC_OFS_MASTER_GAIN 8'h10

// Threshold and loop gain word.
`define AGC_SYNC_EN_BIT     29
`define AGC_THR_MSB         28
`define AGC_THR_LSB         16
`define AGC_G1_MANT_MSB     15
`define AGC_G1_MANT_LSB     12
`define AGC_G1_EXP_MSB      11
`define AGC_G1_EXP_LSB      8
`define AGC_G0_MANT_MSB     7
`define AGC_G0_MANT_LSB     4
`define AGC_G0_EXP_MSB      3
`define AGC_G0_EXP_LSB      0
`define AGC_THR_GAINS_MASK  32'h3fffffff
`define AGC_THR_GAINS_RESET 32'h00000000

// Gain limit word.
`define AGC_UPPER_MSB       27
`define AGC_UPPER_LSB       16
`define AGC_LOWER_MSB       11
`define AGC_LOWER_LSB       0
`define AGC_LIMITS_MASK     32'h0fff0fff
`define AGC_LIMITS_RESET    32'h0fff0000
`define AGC_MASTER_RESET    12'h000

// Loop accumulator: gain code sits above this many extra fraction bits.
`define AGC_ACC_FRAC        23
`define AGC_CODE_EXP_MSB    11
`define AGC_CODE_EXP_LSB    8

`endif

// ==== inc/agc_loop_control_pkg.sv ====
`default_nettype none
package agc_loop_control_pkg;
  typedef logic        [11:0] gain_code_type;
  typedef logic signed [15:0] sample_type;
  typedef logic signed [36:0] loop_acc_type;
  typedef logic signed [13:0] gain_error_type;
endpackage : agc_loop_control_pkg
`default_nettype wire

// ==== src/agc_sample_fifo.sv ====
`timescale 1ns/10ps
`default_nettype none
module agc_sample_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready_o = (count != (AW+1)'(DEPTH));
  assign push       = in_valid_i && in_ready_o;
  assign pop        = (count != '0) && (!out_valid_o || out_ready_i);

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + AW'(1);
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // The read word is registered so the consumer sees flop outputs only.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
    end else if (pop) begin
      out_valid_o <= 1'b1;
      out_data_o  <= mem[rd_ptr];
    end else if (out_ready_i) begin
      out_valid_o <= 1'b0;
    end
  end
endmodule : agc_sample_fifo
`default_nettype wire

// ==== src/agc_gain_scale.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "agc_loop_control_cfg.svh"
module agc_gain_scale #(
  parameter int W = 16
) (
  input  wire logic signed [W-1:0] sample_i,
  input  wire logic        [11:0]  code_i,
  output logic signed      [W-1:0] scaled_o
);
  logic signed [W+9:0]  prod;
  logic signed [W+24:0] wide;

  // Code is eeee.mmmmmmmm: linear gain (1 + m/256) * 2^e. [R10]
  always_comb begin
    prod = sample_i * $signed({2'b01, code_i[7:0]});
    wide = $signed({{15{prod[W+9]}}, prod}) <<< code_i[`AGC_CODE_EXP_MSB:`AGC_CODE_EXP_LSB];
    if ((&wide[W+24:W+7]) || ~(|wide[W+24:W+7])) begin
      scaled_o = wide[W+7:8];
    end else if (wide[W+24]) begin
      scaled_o = {1'b1, {(W-1){1'b0}}};
    end else begin
      scaled_o = {1'b0, {(W-1){1'b1}}};
    end
  end
endmodule : agc_gain_scale
`default_nettype wire

// ==== src/agc_loop_control.sv ====
// Notes on behaviour
// R1: All AGC registers live on the processing clock.
// R2: Sync pin loads master gain when enabled.
// R3: Gain error is threshold minus magnitude.
// R4: Threshold is signed, LSB weight two^-10.
// R5: Host allows for converter magnitude gain 1.647.
// R6: Select high uses gain set one.
// R7: Select low uses gain set zero.
// R8: Step equals 1.5dB x error x mantissa x 2^-(15-e).
// R9: Mantissa code means value over sixteen.
// R10: Limit code is exponent plus offset-binary mantissa.
// R11: Gain clamped between upper and lower limits.
// R12: Strobe write captures loop output for reading.
`timescale 1ns/10ps
`default_nettype none
`include "agc_loop_control_cfg.svh"
module agc_loop_control (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  input  wire logic        external_filter_sync_in_i,
  input  wire logic        loop_gain_set_select_i,
  input  wire logic [15:0] fir_i_i,
  input  wire logic [15:0] fir_q_i,
  input  wire logic [11:0] magnitude_i,
  input  wire logic        fir_valid_i,
  output logic             fir_ready_o,
  output logic      [15:0] resamp_i_o,
  output logic      [15:0] resamp_q_o,
  output logic             resamp_valid_o,
  input  wire logic        resamp_ready_i,
  output logic      [11:0] agc_gain_o
);
  logic [31:0]                         thr_gains;
  logic [31:0]                         limits;
  agc_loop_control_pkg::gain_code_type master_gain;
  agc_loop_control_pkg::gain_code_type held_gain;
  agc_loop_control_pkg::loop_acc_type  acc;
  agc_loop_control_pkg::loop_acc_type  next_acc;
  agc_loop_control_pkg::loop_acc_type  step;
  agc_loop_control_pkg::loop_acc_type  upper_b;
  agc_loop_control_pkg::loop_acc_type  lower_b;
  agc_loop_control_pkg::gain_error_type gain_err;
  agc_loop_control_pkg::gain_code_type gain_code;
  agc_loop_control_pkg::sample_type    scaled_i;
  agc_loop_control_pkg::sample_type    scaled_q;
  logic signed [18:0]                  err_x_mant;
  logic [3:0]                          sel_mant;
  logic [3:0]                          sel_exp;
  logic                                accept;
  logic                                sync_load;
  logic                                strobe_wr;
  logic                                stage_valid;
  logic [31:0]                         stage_data;
  logic                                fifo_in_ready;
  logic [31:0]                         fifo_out;

  assign strobe_wr = wr_i && (addr_i == `AGC_OFS_STROBE);

  // Everything below runs on sys_clk_i; no second sample clock exists here. [R1]
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      thr_gains <= `AGC_THR_GAINS_RESET;
    end else if (wr_i && (addr_i == `AGC_OFS_THR_GAINS)) begin
      thr_gains <= wdata_i & `AGC_THR_GAINS_MASK;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      limits <= `AGC_LIMITS_RESET;
    end else if (wr_i && (addr_i == `AGC_OFS_LIMITS)) begin
      limits <= wdata_i & `AGC_LIMITS_MASK;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      master_gain <= `AGC_MASTER_RESET;
    end else if (wr_i && (addr_i == `AGC_OFS_MASTER_GAIN)) begin
      master_gain <= wdata_i[11:0];
    end
  end

  // The loop output keeps moving every sample, so software reads a frozen copy. [R12]
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      held_gain <= '0;
    end else if (strobe_wr) begin
      held_gain <= gain_code;
    end
  end

  // Read data stand one cycle after rd_i; unmapped and write-only read zero.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= '0;
      if (rd_i) begin
        case (addr_i)
          `AGC_OFS_THR_GAINS:   rdata_o <= thr_gains;
          `AGC_OFS_LIMITS:      rdata_o <= limits;
          `AGC_OFS_HELD_GAIN:   rdata_o <= {20'h00000, held_gain};
          `AGC_OFS_MASTER_GAIN: rdata_o <= {20'h00000, master_gain};
          default:              rdata_o <= '0;
        endcase
      end
    end
  end

  // Gain set choice follows the select pin. [R6] [R7]
  always_comb begin
    if (loop_gain_set_select_i) begin
      sel_mant = thr_gains[`AGC_G1_MANT_MSB:`AGC_G1_MANT_LSB];
      sel_exp  = thr_gains[`AGC_G1_EXP_MSB:`AGC_G1_EXP_LSB];
    end else begin
      sel_mant = thr_gains[`AGC_G0_MANT_MSB:`AGC_G0_MANT_LSB];
      sel_exp  = thr_gains[`AGC_G0_EXP_MSB:`AGC_G0_EXP_LSB];
    end
  end

  // Both threshold and magnitude carry ten fraction bits. [R3] [R4]
  assign gain_err = $signed({thr_gains[`AGC_THR_MSB], thr_gains[`AGC_THR_MSB:`AGC_THR_LSB]})
                  - $signed({2'b00, magnitude_i});

  // Accumulator LSB is 2^-31 of an octave; 1.5dB is taken as a quarter octave, so
  // err*2^-10 * 2^-2 * m/16 * 2^(e-15) lands on the unit exactly. [R8] [R9]
  assign err_x_mant = gain_err * $signed({1'b0, sel_mant});
  assign step       = $signed({{18{err_x_mant[18]}}, err_x_mant}) <<< sel_exp;

  assign upper_b = $signed({2'b00, limits[`AGC_UPPER_MSB:`AGC_UPPER_LSB], {`AGC_ACC_FRAC{1'b0}}});
  assign lower_b = $signed({2'b00, limits[`AGC_LOWER_MSB:`AGC_LOWER_LSB], {`AGC_ACC_FRAC{1'b0}}});

  // Upper is checked first, so with crossed limits a sum above upper settles there and any other sum at the lower one. [R11]
  always_comb begin
    next_acc = acc + step;
    if (next_acc > upper_b) begin
      next_acc = upper_b;
    end else if (next_acc < lower_b) begin
      next_acc = lower_b;
    end
  end

  assign sync_load = thr_gains[`AGC_SYNC_EN_BIT] && external_filter_sync_in_i;
  assign accept    = fir_valid_i && fir_ready_o;

  // A sync pulse outranks a sample update in the same cycle. [R2]
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      acc <= '0;
    end else if (sync_load) begin
      acc <= $signed({2'b00, master_gain, {`AGC_ACC_FRAC{1'b0}}});
    end else if (accept) begin
      acc <= next_acc;
    end
  end

  assign gain_code  = acc[34:`AGC_ACC_FRAC];
  assign agc_gain_o = held_gain;

  agc_gain_scale #(.W(16)) u_scale_i (
    .sample_i (fir_i_i),
    .code_i   (gain_code),
    .scaled_o (scaled_i)
  );

  agc_gain_scale #(.W(16)) u_scale_q (
    .sample_i (fir_q_i),
    .code_i   (gain_code),
    .scaled_o (scaled_q)
  );

  // One stage ahead of the buffer; a full buffer stalls the filter input.
  assign fir_ready_o = !stage_valid || fifo_in_ready;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      stage_valid <= 1'b0;
      stage_data  <= '0;
    end else if (accept) begin
      stage_valid <= 1'b1;
      stage_data  <= {scaled_i, scaled_q};
    end else if (fifo_in_ready) begin
      stage_valid <= 1'b0;
    end
  end

  agc_sample_fifo #(.WIDTH(32), .DEPTH(16)) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .rst_i       (rst_i),
    .in_data_i   (stage_data),
    .in_valid_i  (stage_valid),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_out),
    .out_valid_o (resamp_valid_o),
    .out_ready_i (resamp_ready_i)
  );

  assign resamp_i_o = fifo_out[31:16];
  assign resamp_q_o = fifo_out[15:0];

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  property p_strobe_capture;
    strobe_wr |=> (held_gain == $past(gain_code));
  endproperty
  a_strobe_capture: assert property (p_strobe_capture) // [R12]
    else $error("Strobe did not capture loop output.");

  property p_held_stable;
    !strobe_wr |=> $stable(held_gain);
  endproperty
  a_held_stable: assert property (p_held_stable) // [R12]
    else $error("Held gain moved without a strobe.");

  property p_held_readback;
    rd_i && (addr_i == `AGC_OFS_HELD_GAIN) |=> (rdata_o == {20'h00000, held_gain});
  endproperty
  a_held_readback: assert property (p_held_readback) // [R1]
    else $error("Held gain read back wrong.");

  property p_sync_load;
    sync_load |=> (acc == $signed({2'b00, $past(master_gain), {`AGC_ACC_FRAC{1'b0}}}));
  endproperty
  a_sync_load: assert property (p_sync_load) // [R2]
    else $error("Sync did not load master gain.");

  property p_no_sync;
    !thr_gains[`AGC_SYNC_EN_BIT] && !accept |=> $stable(acc);
  endproperty
  a_no_sync: assert property (p_no_sync) // [R2]
    else $error("Accumulator moved with sync disabled and no sample.");

  property p_upper_clamp;
    accept && !sync_load && (upper_b >= lower_b) |=> (acc <= $past(upper_b));
  endproperty
  a_upper_clamp: assert property (p_upper_clamp) // [R11]
    else $error("Gain exceeded upper limit.");

  property p_lower_clamp;
    accept && !sync_load && (upper_b >= lower_b) |=> (acc >= $past(lower_b));
  endproperty
  a_lower_clamp: assert property (p_lower_clamp) // [R11]
    else $error("Gain fell below lower limit.");

  property p_set1_zero;
    accept && !sync_load && loop_gain_set_select_i && (thr_gains[15:12] == 4'h0)
      && (acc >= lower_b) && (acc <= upper_b) |=> $stable(acc);
  endproperty
  a_set1_zero: assert property (p_set1_zero) // [R6]
    else $error("Gain set one not in use while selected.");

  property p_set0_zero;
    accept && !sync_load && !loop_gain_set_select_i && (thr_gains[7:4] == 4'h0)
      && (acc >= lower_b) && (acc <= upper_b) |=> $stable(acc);
  endproperty
  a_set0_zero: assert property (p_set0_zero) // [R7]
    else $error("Gain set zero not in use while selected.");

  property p_error_down;
    accept && !sync_load && (sel_mant != 4'h0) && (gain_err < 0)
      && (acc > lower_b) && (acc <= upper_b) |=> (acc < $past(acc));
  endproperty
  a_error_down: assert property (p_error_down) // [R3]
    else $error("Negative gain error did not lower the gain.");

  property p_step_size;
    accept && !sync_load && (acc + step <= upper_b) && (acc + step >= lower_b)
      ##1 !sync_load && !accept |=> (acc == $past(acc, 2) + $past(step, 2));
  endproperty
  a_step_size: assert property (p_step_size) // [R8]
    else $error("Loop step has wrong size.");

  property p_rdata_idle;
    !rd_i |=> (rdata_o == 32'h00000000);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) // [R1]
    else $error("Read data not zero outside a read.");

  property p_thr_write;
    wr_i && (addr_i == `AGC_OFS_THR_GAINS) |=> (thr_gains == ($past(wdata_i) & `AGC_THR_GAINS_MASK));
  endproperty
  a_thr_write: assert property (p_thr_write) // [R4]
    else $error("Threshold word write did not land.");

  property p_limits_write;
    wr_i && (addr_i == `AGC_OFS_LIMITS) |=> (limits == ($past(wdata_i) & `AGC_LIMITS_MASK));
  endproperty
  a_limits_write: assert property (p_limits_write) // [R11]
    else $error("Limit word write did not land.");

  property p_thr_negative;
    thr_gains[`AGC_THR_MSB] |-> (gain_err < 0);
  endproperty
  a_thr_negative: assert property (p_thr_negative) // [R4]
    else $error("Negative threshold gave a non-negative error.");

  property p_error_up;
    accept && !sync_load && (sel_mant != 4'h0) && (gain_err > 0)
      && (acc >= lower_b) && (acc < upper_b) |=> (acc > $past(acc));
  endproperty
  a_error_up: assert property (p_error_up) // [R3]
    else $error("Positive gain error did not raise the gain.");

  property p_sel_one;
    loop_gain_set_select_i |-> (sel_mant == thr_gains[`AGC_G1_MANT_MSB:`AGC_G1_MANT_LSB])
      && (sel_exp == thr_gains[`AGC_G1_EXP_MSB:`AGC_G1_EXP_LSB]);
  endproperty
  a_sel_one: assert property (p_sel_one) // [R6]
    else $error("Gain set one fields not selected.");

  property p_sel_zero;
    !loop_gain_set_select_i |-> (sel_mant == thr_gains[`AGC_G0_MANT_MSB:`AGC_G0_MANT_LSB])
      && (sel_exp == thr_gains[`AGC_G0_EXP_MSB:`AGC_G0_EXP_LSB]);
  endproperty
  a_sel_zero: assert property (p_sel_zero) // [R7]
    else $error("Gain set zero fields not selected.");

  // A mantissa code of eight is one half, so the step is the error shifted three further.
  property p_mant_half;
    (sel_mant == 4'h8) |-> (step == ($signed({{23{gain_err[13]}}, gain_err}) <<< ({1'b0, sel_exp} + 5'h03)));
  endproperty
  a_mant_half: assert property (p_mant_half) // [R9]
    else $error("Mantissa half did not halve the step.");

  property p_scale_exp;
    (gain_code == 12'h300) && ($signed(fir_i_i) >= -16'sh1000) && ($signed(fir_i_i) < 16'sh1000)
      |-> (scaled_i == $signed({fir_i_i[12:0], 3'h0}));
  endproperty
  a_scale_exp: assert property (p_scale_exp) // [R10]
    else $error("Exponent three did not scale by eight.");

  property p_stage_capture;
    accept |=> (stage_data == {$past(scaled_i), $past(scaled_q)});
  endproperty
  a_stage_capture: assert property (p_stage_capture) // [R8]
    else $error("Scaled sample not staged.");

  property p_gain_pin;
    strobe_wr |=> (agc_gain_o == $past(gain_code));
  endproperty
  a_gain_pin: assert property (p_gain_pin) // [R12]
    else $error("Gain pin did not follow the strobe.");
endmodule : agc_loop_control
`default_nettype wire

// ==== test/agc_resamp_sink.sv ====
`timescale 1ns/10ps
`default_nettype none
module agc_resamp_sink (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic [1:0] mode_i,
  output logic            ready_o
);
  // Mode 0 stalls, mode 1 takes every word, mode 2 takes words at random with ready drawn afresh on every cycle.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || mode_i == 2'h0) begin
      ready_o <= 1'h0;
    end else if (mode_i == 2'h1) begin
      ready_o <= 1'h1;
    end else begin
      ready_o <= 1'($urandom_range(0, 1));
    end
  end
endmodule : agc_resamp_sink
`default_nettype wire

// ==== test/tb_agc_loop_control.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "agc_loop_control_cfg.svh"
module tb_agc_loop_control;
  logic        sys_clk_i = 1'h0;
  logic        rst_i     = 1'h1;
  logic [7:0]  addr_i    = 8'h00;
  logic [31:0] wdata_i   = 32'h0;
  logic        wr_i      = 1'h0;
  logic        rd_i      = 1'h0;
  logic        sync_in   = 1'h0;
  logic        sel       = 1'h0;
  logic [15:0] fir_i_i   = 16'h0;
  logic [15:0] fir_q_i   = 16'h0;
  logic [11:0] magnitude_i = 12'h0;
  logic        fir_valid_i = 1'h0;
  logic [1:0]  sink_mode = 2'h1;
  logic        fir_ready_o, resamp_valid_o, resamp_ready_i;
  logic [31:0] rdata_o;
  logic [15:0] resamp_i_o, resamp_q_o;
  logic [11:0] agc_gain_o;
  int          failures = 0;
  int          checks   = 0;
  int          thr, mag, m0, e0, m1, e1, up, lo, g, master, held, cur_i, cur_q, k, j, sync_en;
  longint      acc;
  logic [31:0] expq[$];
  logic [7:0]  radr[6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
  logic [31:0] rrst[6] = '{32'h0, 32'h0fff0000, 32'h0, 32'h0, 32'h0, 32'h0};

  always #10 sys_clk_i = ~sys_clk_i;

  agc_loop_control i_agc_loop_control (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .external_filter_sync_in_i(sync_in),
    .loop_gain_set_select_i(sel), .fir_i_i(fir_i_i), .fir_q_i(fir_q_i), .magnitude_i(magnitude_i),
    .fir_valid_i(fir_valid_i), .fir_ready_o(fir_ready_o), .resamp_i_o(resamp_i_o), .resamp_q_o(resamp_q_o),
    .resamp_valid_o(resamp_valid_o), .resamp_ready_i(resamp_ready_i), .agc_gain_o(agc_gain_o));
  agc_resamp_sink i_agc_resamp_sink (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .mode_i(sink_mode),
    .ready_o(resamp_ready_i));

  task finish_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Saturating scale by (1 + m/256) * 2^e, rounded toward minus infinity.
  function automatic logic [15:0] scale(input int s, input int c);
    longint v;
    v = ((longint'(s) * (256 + (c & 255))) <<< (c >> 8)) >>> 8;
    if (v > 32767) v = 32767;
    else if (v < -32768) v = -32768;
    return v[15:0];
  endfunction : scale

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    wr_i <= 1'h1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge sys_clk_i);
    wr_i <= 1'h0;
    wdata_i <= ~d;
    if (a == `AGC_OFS_THR_GAINS) begin
      sync_en = d[29];
      thr = int'($signed(d[28:16]));
      {m1, e1, m0, e0} = {28'h0, d[15:12], 28'h0, d[11:8], 28'h0, d[7:4], 28'h0, d[3:0]};
    end
    if (a == `AGC_OFS_LIMITS) {up, lo} = {20'h0, d[27:16], 20'h0, d[11:0]};
    if (a == `AGC_OFS_MASTER_GAIN) master = int'(d[11:0]);
    if (a == `AGC_OFS_STROBE) held = g;
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] exp, input string name);
    @(posedge sys_clk_i);
    rd_i <= 1'h1;
    addr_i <= a;
    @(posedge sys_clk_i);
    rd_i <= 1'h0;
    @(posedge sys_clk_i);
    chk(name, rdata_o, exp);
  endtask : rd

  task pulse_sync;
    @(posedge sys_clk_i);
    sync_in <= 1'h1;
    @(posedge sys_clk_i);
    sync_in <= 1'h0;
    if (sync_en == 1) begin
      g = master;
      acc = longint'(g) <<< 23;
    end
  endtask : pulse_sync

  task strobe_and_read;
    wr(`AGC_OFS_STROBE, 32'h0);
    rd(`AGC_OFS_HELD_GAIN, held, "held");
    chk("gain_out", {20'h0, agc_gain_o}, held);
  endtask : strobe_and_read

  task new_data;
    cur_i = (int'($urandom_range(0, 255)) - 128) * 32;
    cur_q = (int'($urandom_range(0, 255)) - 128) * 32;
    fir_i_i <= cur_i[15:0];
    fir_q_i <= cur_q[15:0];
    magnitude_i <= mag[11:0];
  endtask : new_data

  // Behavioural loop: gain used for a sample is the one before that sample's own update.
  task accept;
    expq.push_back({scale(cur_i, g), scale(cur_q, g)});
    acc = acc + ((longint'((thr - mag) * (sel ? m1 : m0))) <<< (sel ? e1 : e0));
    if (acc > (longint'(up) <<< 23)) acc = longint'(up) <<< 23;
    else if (acc < (longint'(lo) <<< 23)) acc = longint'(lo) <<< 23;
    g = int'(acc >>> 23);
  endtask : accept

  task send(input int n);
    int b;
    k = 0;
    b = 0;
    new_data();
    fir_valid_i <= 1'h1;
    while (k < n && b < 80) begin
      @(posedge sys_clk_i);
      b++;
      if (fir_ready_o === 1'h1) begin
        accept();
        k++;
        new_data();
      end
    end
    fir_valid_i <= 1'h0;
  endtask : send

  task drain;
    int b;
    b = 0;
    while (expq.size() > 0 && b < 600) begin
      @(posedge sys_clk_i);
      b++;
    end
    if (expq.size() > 0) begin
      failures++;
      finish_test();
    end
  endtask : drain

  always @(posedge sys_clk_i) begin
    if (!rst_i && resamp_valid_o === 1'h1 && resamp_ready_i === 1'h1) begin
      if (expq.size() == 0) chk("extra_out", 32'h1, 32'h0);
      else chk("resamp", {resamp_i_o, resamp_q_o}, expq.pop_front());
    end
  end

  initial begin
    repeat (100000) @(posedge sys_clk_i);
    failures++;
    finish_test();
  end

  initial begin
    void'($urandom(33684));
    {g, acc, held, master, mag, sync_en} = '0;
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'h0;
    for (j = 0; j < 6; j++) rd(radr[j], rrst[j], "reset");
    wr(`AGC_OFS_THR_GAINS, 32'hffffffff);
    rd(`AGC_OFS_THR_GAINS, 32'h3fffffff, "cfg_mask");
    wr(`AGC_OFS_LIMITS, 32'hffffffff);
    rd(`AGC_OFS_LIMITS, 32'h0fff0fff, "lim_mask");
    rd(`AGC_OFS_STROBE, 32'h0, "strobe_wo");
    wr(`AGC_OFS_LIMITS, 32'h034000f0);
    wr(`AGC_OFS_MASTER_GAIN, 32'h00000300);
    // Threshold raw values already allow for the converter's magnitude gain.
    wr(`AGC_OFS_THR_GAINS, 32'h2200008f);
    pulse_sync();
    strobe_and_read();
    mag = 256;
    send(4);
    sel <= 1'h1;
    send(3);
    strobe_and_read();
    sel <= 1'h0;
    send(6);
    strobe_and_read();
    mag = 768;
    send(2);
    rd(`AGC_OFS_HELD_GAIN, held, "held_stable");
    wr(`AGC_OFS_MASTER_GAIN, 32'h00000100);
    pulse_sync();
    send(4);
    strobe_and_read();
    wr(`AGC_OFS_THR_GAINS, 32'h02000000);
    wr(`AGC_OFS_MASTER_GAIN, 32'h00000200);
    pulse_sync();
    strobe_and_read();
    drain();
    sink_mode <= 2'h0;
    send(30);
    chk("fill_count", {31'h0, k >= 17 && k <= 18}, 32'h1);
    chk("refused", {31'h0, fir_ready_o}, 32'h0);
    sink_mode <= 2'h2;
    drain();
    send(20);
    drain();
    finish_test();
  end
endmodule : tb_agc_loop_control
`default_nettype wire
